/* File: rtl/rff_pkg.sv */
// rff_pkg: constants and types for the receive frame acceptance filter
package rff_pkg;
	// ==========================================================
	// register map (word indices, byte address is four times)
	localparam logic [7:0] RFF_IDX_NET_ADDRESS = 8'h03;
	localparam logic [7:0] RFF_IDX_SYS_CONFIG = 8'h04;
	localparam logic [7:0] RFF_IDX_FILTER_STATUS = 8'h05;
	localparam logic [7:0] RFF_ADDR_NET_ADDRESS = 8'h0C;
	localparam logic [7:0] RFF_ADDR_SYS_CONFIG = 8'h10;
	localparam logic [7:0] RFF_ADDR_FILTER_STATUS = 8'h14;

	// ==========================================================
	// reset values
	localparam logic [31:0] RFF_RST_NET_ADDRESS = 32'hFFFFFFFF;
	localparam logic [31:0] RFF_RST_SYS_CONFIG = 32'h00001200;

	// ==========================================================
	// configuration bit positions
	localparam int RFF_BIT_FILTER_ON = 0;
	localparam int RFF_BIT_COORD = 1;
	localparam int RFF_BIT_BEACON = 2;
	localparam int RFF_BIT_DATA = 3;
	localparam int RFF_BIT_ACK = 4;
	localparam int RFF_BIT_CMD = 5;
	localparam int RFF_BIT_RESERVED = 6;
	localparam int RFF_BIT_TYPE4 = 7;
	localparam int RFF_BIT_TYPE5 = 8;

	// ==========================================================
	// frame control field layout and codes
	localparam logic [2:0] RFF_TYPE_BEACON = 3'h0;
	localparam logic [2:0] RFF_TYPE_DATA = 3'h1;
	localparam logic [2:0] RFF_TYPE_ACK = 3'h2;
	localparam logic [2:0] RFF_TYPE_CMD = 3'h3;
	localparam logic [2:0] RFF_TYPE_FOUR = 3'h4;
	localparam logic [2:0] RFF_TYPE_FIVE = 3'h5;
	localparam int RFF_FCF_COMPRESS = 6;
	localparam logic [1:0] RFF_MODE_NONE = 2'h0;
	localparam logic [1:0] RFF_MODE_SHORT = 2'h2;
	localparam logic [1:0] RFF_MODE_LONG = 2'h3;
	localparam logic [6:0] RFF_OFS_DPAN = 7'h03;
	localparam logic [6:0] RFF_LEN_PAN = 7'h02;
	localparam logic [6:0] RFF_LEN_SHORT = 7'h02;
	localparam logic [6:0] RFF_LEN_LONG = 7'h08;
	localparam logic [6:0] RFF_LEN_FCS = 7'h02;

	typedef struct packed {
		logic valid;
		logic first;
		logic last;
		logic [7:0] data;
	} rff_rx_byte_t;

	typedef enum logic [1:0] {
		RFF_ST_IDLE = 2'b00,
		RFF_ST_BODY = 2'b01
	} rff_state_t;
endpackage

/* File: rtl/rff_frame_filter.sv */
// rff_frame_filter: decodes each received frame and accepts or rejects it
`timescale 1ns/1ps
`default_nettype none

// Operation
// - filter checks apply only while frame_filter_on is set; otherwise every frame passes.
// - short destination must equal node short address and node network identifier.
// - coordinator role has effect only while frame_filter_on is set.
// - coordinator_role 1 acts as coordinator, 0 as ordinary node.
// - coordinator accepts no-destination frame when source network identifier matches.
// - ordinary node rejects a frame whose destination is not its own address.
// - beacon type 000 accepted only with allow_beacon set and other checks passing.
// - data type 001 accepted only with allow_data_frames set and checks passing.
// - ack type 010 accepted only with allow_ack_frames set and checks passing.
// - command type 011 accepted only with allow_mac_command set and checks passing.
// - type codes 100 to 111 are reserved and normally rejected.
// - allow_reserved_types set accepts every type 100 to 111.
// - reserved types rejected when that bit clear, unless type four/five allows.
// - accepted reserved frames skip address matching, handed on for software.
// - allow_type_four set accepts type 100 without address matching.
// - allow_type_four clear rejects type 100 unless allow_reserved_types set.
// - frames shorter than the length implied by frame control are rejected.
module rff_frame_filter
	import rff_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [31:0] rd_data_out,
	input wire rff_rx_byte_t rx_byte_in,
	output logic frame_good_out,
	output logic frame_drop_out
);
	// ==========================================================
	// registers
	logic [31:0] net_address;
	logic [31:0] sys_config;
	logic [15:0] good_count;
	logic [15:0] drop_count;
	logic [31:0] next_rd_data;

	wire sel_net = (addr_in == RFF_ADDR_NET_ADDRESS);
	wire sel_cfg = (addr_in == RFF_ADDR_SYS_CONFIG);
	wire sel_sts = (addr_in == RFF_ADDR_FILTER_STATUS);

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			net_address <= RFF_RST_NET_ADDRESS;
			sys_config <= RFF_RST_SYS_CONFIG;
		end else if (wr_en_in) begin
			if (sel_net) begin
				net_address <= wr_data_in;
			end
			if (sel_cfg) begin
				sys_config <= wr_data_in;
			end
		end
	end

	// unmapped addresses read as zero
	always_comb begin
		next_rd_data = 32'h00000000;
		if (rd_en_in && sel_net) begin
			next_rd_data = net_address;
		end else if (rd_en_in && sel_cfg) begin
			next_rd_data = sys_config;
		end else if (rd_en_in && sel_sts) begin
			next_rd_data = {drop_count, good_count};
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rd_data_out <= 32'h00000000;
		end else begin
			rd_data_out <= next_rd_data;
		end
	end

	wire [15:0] own_short = net_address[15:0];
	wire [15:0] own_net_id = net_address[31:16];
	wire filter_on = sys_config[RFF_BIT_FILTER_ON];
	wire coord = filter_on & sys_config[RFF_BIT_COORD];

	// ==========================================================
	// byte tracking and field capture
	rff_state_t state;
	rff_state_t next_state;
	logic [6:0] idx;
	logic [15:0] fcf;
	logic [15:0] dst_pan;
	logic [15:0] dst_addr;
	logic [15:0] src_pan;

	wire rx_take = rx_byte_in.valid & (rx_byte_in.first | (state == RFF_ST_BODY));
	wire [6:0] cur_idx = rx_byte_in.first ? 7'h00 : idx;

	always_comb begin
		next_state = state;
		case (state)
			RFF_ST_IDLE: begin
				if (rx_take && !rx_byte_in.last) begin
					next_state = RFF_ST_BODY;
				end
			end
			RFF_ST_BODY: begin
				if (rx_take && rx_byte_in.last) begin
					next_state = RFF_ST_IDLE;
				end
			end
			default: begin
				next_state = RFF_ST_IDLE;
			end
		endcase
	end

	// field offsets follow from the frame control field
	wire [2:0] ftype = fcf[2:0];
	wire [1:0] dst_mode = fcf[11:10];
	wire [1:0] src_mode = fcf[15:14];
	wire dst_present = (dst_mode != RFF_MODE_NONE);
	wire src_present = (src_mode != RFF_MODE_NONE);
	wire src_pan_present = src_present & ~(fcf[RFF_FCF_COMPRESS] & dst_present);
	wire [6:0] dst_len = (dst_mode == RFF_MODE_SHORT) ? RFF_LEN_SHORT :
		(dst_mode == RFF_MODE_LONG) ? RFF_LEN_LONG : 7'h00;
	wire [6:0] src_len = (src_mode == RFF_MODE_SHORT) ? RFF_LEN_SHORT :
		(src_mode == RFF_MODE_LONG) ? RFF_LEN_LONG : 7'h00;
	wire [6:0] ofs_daddr = RFF_OFS_DPAN + (dst_present ? RFF_LEN_PAN : 7'h00);
	wire [6:0] ofs_span = ofs_daddr + dst_len;
	wire [6:0] ofs_saddr = ofs_span + (src_pan_present ? RFF_LEN_PAN : 7'h00);
	wire [6:0] min_len = ofs_saddr + src_len + RFF_LEN_FCS;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state <= RFF_ST_IDLE;
			idx <= 7'h00;
			fcf <= 16'h0000;
			dst_pan <= 16'h0000;
			dst_addr <= 16'h0000;
			src_pan <= 16'h0000;
		end else begin
			state <= next_state;
			if (rx_take) begin
				idx <= cur_idx + 7'h01;
				if (cur_idx == 7'h00) begin
					fcf[7:0] <= rx_byte_in.data;
				end
				if (cur_idx == 7'h01) begin
					fcf[15:8] <= rx_byte_in.data;
				end
				if (cur_idx == RFF_OFS_DPAN) begin
					dst_pan[7:0] <= rx_byte_in.data;
				end
				if (cur_idx == RFF_OFS_DPAN + 7'h01) begin
					dst_pan[15:8] <= rx_byte_in.data;
				end
				if (cur_idx == ofs_daddr) begin
					dst_addr[7:0] <= rx_byte_in.data;
				end
				if (cur_idx == ofs_daddr + 7'h01) begin
					dst_addr[15:8] <= rx_byte_in.data;
				end
				if (cur_idx == ofs_span) begin
					src_pan[7:0] <= rx_byte_in.data;
				end
				if (cur_idx == ofs_span + 7'h01) begin
					src_pan[15:8] <= rx_byte_in.data;
				end
			end
		end
	end

	// ==========================================================
	// verdict, formed on the last byte of a frame
	wire frame_end = rx_take & rx_byte_in.last;
	// fcf is only complete once two bytes are in; shorter frames fail the length check anyway
	wire [7:0] frame_len = {1'b0, cur_idx} + 8'h01;
	wire length_ok = (cur_idx >= 7'h02) && (frame_len >= {1'b0, min_len});

	wire is_reserved = ftype[2];
	wire reserved_ok = sys_config[RFF_BIT_RESERVED] |
		((ftype == RFF_TYPE_FOUR) & sys_config[RFF_BIT_TYPE4]) |
		((ftype == RFF_TYPE_FIVE) & sys_config[RFF_BIT_TYPE5]);

	wire type_ok = ((ftype == RFF_TYPE_BEACON) & sys_config[RFF_BIT_BEACON]) |
		((ftype == RFF_TYPE_DATA) & sys_config[RFF_BIT_DATA]) |
		((ftype == RFF_TYPE_ACK) & sys_config[RFF_BIT_ACK]) |
		((ftype == RFF_TYPE_CMD) & sys_config[RFF_BIT_CMD]);

	// with pan compression the source shares the destination network identifier
	wire [15:0] src_net = src_pan_present ? src_pan : dst_pan;
	wire src_net_ok = src_present & (src_net == own_net_id);
	// 64-bit destinations are not matched here, so they never pass
	wire dst_ok = (dst_mode == RFF_MODE_SHORT) &
		(dst_addr == own_short) & (dst_pan == own_net_id);
	wire nodst_ok = (ftype == RFF_TYPE_ACK) |
		(coord & src_net_ok) |
		(~coord & (ftype == RFF_TYPE_BEACON) & src_net_ok);
	wire addr_ok = dst_present ? dst_ok : nodst_ok;

	// reserved types bypass address decoding entirely
	wire checks_ok = length_ok & (is_reserved ? reserved_ok : (type_ok & addr_ok));
	wire accept = ~filter_on | checks_ok;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			frame_good_out <= 1'b0;
			frame_drop_out <= 1'b0;
			good_count <= 16'h0000;
			drop_count <= 16'h0000;
		end else begin
			frame_good_out <= frame_end & accept;
			frame_drop_out <= frame_end & ~accept;
			if (frame_end && accept) begin
				good_count <= good_count + 16'h0001;
			end
			if (frame_end && !accept) begin
				drop_count <= drop_count + 16'h0001;
			end
		end
	end
endmodule

`default_nettype wire

/* File: verification/rff_chk.sv */
// rff_chk: port-level assertions for the frame filter
`timescale 1ns/1ps
`default_nettype none
module rff_chk
	import rff_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [31:0] rd_data_out,
	input wire rff_rx_byte_t rx_byte_in,
	input wire logic frame_good_out,
	input wire logic frame_drop_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// ========
	// shadow state: config as written, type of the frame in flight
	logic [31:0] cfg;
	logic [2:0] ftype;
	logic [2:0] ty;
	logic fin_on;
	assign ty = rx_byte_in.first ? rx_byte_in.data[2:0] : ftype;
	assign fin_on = rx_byte_in.valid && rx_byte_in.last && cfg[RFF_BIT_FILTER_ON];
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cfg <= RFF_RST_SYS_CONFIG;
			ftype <= 3'h0;
		end else begin
			if (wr_en_in && addr_in == RFF_ADDR_SYS_CONFIG) begin
				cfg <= wr_data_in;
			end
			if (rx_byte_in.valid && rx_byte_in.first) begin
				ftype <= rx_byte_in.data[2:0];
			end
		end
	end
	// ========
	// assertions
	AST_ONE_VERDICT: assert property (!(frame_good_out && frame_drop_out))
		else $error("good and drop together");
	AST_VERDICT_CAUSE: assert property ((frame_good_out || frame_drop_out) |->
		$past(rx_byte_in.valid && rx_byte_in.last)) else $error("verdict without last");
	AST_RD_IDLE: assert property (!$past(rd_en_in) |-> rd_data_out == 32'h0)
		else $error("read data outside read");
	AST_RD_CFG: assert property (rd_en_in && addr_in == RFF_ADDR_SYS_CONFIG |=>
		rd_data_out == $past(cfg)) else $error("config readback wrong");
	AST_FILTER_OFF: assert property (rx_byte_in.valid && rx_byte_in.last &&
		!cfg[RFF_BIT_FILTER_ON] |=> !frame_drop_out) else $error("drop with filter off");
	AST_TYPE_BLOCKED: assert property (fin_on && !ty[2] && !cfg[RFF_BIT_BEACON + ty]
		##1 1'b1 |-> !frame_good_out) else $error("blocked type accepted");
	AST_RSV_BLOCKED: assert property (fin_on && ty[2] && !cfg[RFF_BIT_RESERVED] &&
		!(ty == 3'h4 && cfg[RFF_BIT_TYPE4]) && !(ty == 3'h5 && cfg[RFF_BIT_TYPE5])
		|=> !frame_good_out) else $error("reserved type accepted");
	AST_TOO_SHORT: assert property (fin_on && rx_byte_in.first |=> frame_drop_out)
		else $error("one byte frame not dropped");
	cover property (fin_on ##1 frame_good_out);
	cover property (fin_on && ty[2] ##1 frame_drop_out);
	cover property (rd_en_in && addr_in == RFF_ADDR_NET_ADDRESS);
endmodule
`default_nettype wire

/* File: verification/rff_frame_source.sv */
// rff_frame_source: remote node model sending byte streams
`timescale 1ns/1ps
`default_nettype none
module rff_frame_source
	import rff_pkg::*;
(
	input wire logic clk_in,
	output var rff_rx_byte_t rx_byte_out
);
	initial rx_byte_out = '0;
	// each idle cycle that send drives clears valid and inverts the data, so a stale byte never looks valid
	task automatic send(input logic [7:0] fr[$], input int gap);
		for (int i = 0; i < fr.size(); i++) begin
			if (gap != 0 && i != 0) begin
				@(posedge clk_in);
				rx_byte_out <= '{1'b0, 1'b0, 1'b0, ~rx_byte_out.data};
			end
			@(posedge clk_in);
			rx_byte_out <= '{1'b1, i == 0, i == fr.size() - 1, fr[i]};
		end
		@(posedge clk_in);
		rx_byte_out <= '{1'b0, 1'b0, 1'b0, ~rx_byte_out.data};
	endtask
endmodule
`default_nettype wire

/* File: verification/rff_frame_filter_tb_top.sv */
// rff_frame_filter_tb_top: random and directed frames against the filter
`timescale 1ns/1ps
`default_nettype none
module rff_frame_filter_tb_top
	import rff_pkg::*;
;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wr_data_in = 32'h0;
	logic wr_en_in = 1'b0;
	logic rd_en_in = 1'b0;
	logic [31:0] rd_data_out;
	rff_rx_byte_t rx_byte_in;
	logic frame_good_out;
	logic frame_drop_out;
	logic [15:0] ng = 16'h0;
	logic [15:0] nd = 16'h0;
	int n_errors = 0;
	int comparisons = 0;
	int seed = 32'he9fe83b7;
	always #50 clk_in = ~clk_in;
	rff_frame_filter dut (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
		.rd_data_out(rd_data_out), .rx_byte_in(rx_byte_in),
		.frame_good_out(frame_good_out), .frame_drop_out(frame_drop_out));
	rff_frame_source src (.clk_in(clk_in), .rx_byte_out(rx_byte_in));
	task automatic give_verdict();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		@(posedge clk_in);
		wr_en_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_en_in <= 1'b1;
		@(posedge clk_in);
		rd_en_in <= 1'b0;
		#1 d = rd_data_out;
	endtask
	// ========
	// expected verdict for the frame shapes built below
	function automatic logic exp_good(logic [31:0] c, logic [2:0] t, logic [3:0] f);
		if (!c[0]) return 1'b1;
		if (f[0]) return 1'b0;
		if (t[2]) return c[6] | (t == 3'h4 & c[7]) | (t == 3'h5 & c[8]);
		if (f[3]) return c[2 + t] & f[2] & (c[1] | t == 3'h0);
		return c[2 + t] & f[2] & f[1];
	endfunction
	task automatic verdict(input logic e);
		int k;
		for (k = 0; k < 4; k++) begin
			#1;
			if (frame_good_out | frame_drop_out) break;
			@(posedge clk_in);
		end
		if (k == 4) begin
			n_errors++;
			$display("unexpected verdict timeout");
			give_verdict();
		end
		check(frame_good_out, e, "good");
		check(frame_drop_out, !e, "drop");
		if (e) ng = ng + 16'h1;
		else nd = nd + 16'h1;
	endtask
	task automatic one_frame();
		logic [7:0] fr[$];
		logic [31:0] cfg;
		logic [31:0] na;
		logic [31:0] v;
		logic [2:0] t;
		logic [3:0] f;
		logic [15:0] pan;
		logic [15:0] sa;
		cfg = $random(seed) & 32'h000001FF;
		if (($random(seed) & 7) != 0) cfg[0] = 1'b1;
		na = $random(seed);
		t = 3'($random(seed));
		f = 4'($random(seed));
		if (f[3] && t == 3'h2) t = 3'h1;
		pan = f[2] ? na[31:16] : ~na[31:16];
		sa = f[1] ? na[15:0] : ~na[15:0];
		wr(RFF_ADDR_NET_ADDRESS, na);
		wr(RFF_ADDR_SYS_CONFIG, cfg);
		rd(RFF_ADDR_SYS_CONFIG, v);
		check(v, cfg, "config");
		if (f[3]) fr = '{{5'h00, t}, 8'h80, 8'h11, pan[7:0], pan[15:8], 8'h22, 8'h33, 8'h44, 8'h55};
		else fr = '{{5'h08, t}, 8'h88, 8'h11, pan[7:0], pan[15:8], sa[7:0], sa[15:8],
			8'h22, 8'h33, 8'h44, 8'h55};
		if (f[0]) repeat (($random(seed) & 3) + 1) void'(fr.pop_back());
		src.send(fr, $random(seed) & 1);
		verdict(exp_good(cfg, t, f));
	endtask
	initial begin
		logic [31:0] v;
		repeat (3) @(posedge clk_in);
		srst_in <= 1'b0;
		rd(RFF_ADDR_SYS_CONFIG, v);
		check(v, RFF_RST_SYS_CONFIG, "config reset");
		rd(RFF_ADDR_NET_ADDRESS, v);
		check(v, RFF_RST_NET_ADDRESS, "address reset");
		rd(8'h20, v);
		check(v, 32'h0, "unmapped");
		wr(RFF_ADDR_SYS_CONFIG, 32'h00000001);
		src.send('{8'h01}, 0);
		verdict(1'b0);
		repeat (120) one_frame();
		wr(RFF_ADDR_FILTER_STATUS, 32'hFFFFFFFF);
		rd(RFF_ADDR_FILTER_STATUS, v);
		check(v, {nd, ng}, "status");
		give_verdict();
	end
endmodule
bind rff_frame_filter rff_chk chk (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
	.wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
	.rd_data_out(rd_data_out), .rx_byte_in(rx_byte_in),
	.frame_good_out(frame_good_out), .frame_drop_out(frame_drop_out));
`default_nettype wire
